// *** bench/host_wake_monitor.sv ***
/* host side model: latches that a wake request was seen on the wire.
   assumes: same clock and standby reset as the wake block. */
`timescale 1ns/1ps
module host_wake_monitor (
   input wire logic ref_clk_i, // block clock
   input wire logic rstn_i, // standby reset, active low
   input wire logic wake_request_n_i, // request from the block
   output logic wake_seen_o // a request was seen since reset
);
   // request is active low; the flag stays set until reset
   always_ff @(posedge ref_clk_i) begin
      if (!rstn_i) wake_seen_o <= 1'b0;
      else if (!wake_request_n_i) wake_seen_o <= 1'b1;
   end
endmodule : host_wake_monitor

// *** bench/wake_event_status_control_sva.sv ***
/* port checker for the wake event block.
   assumes: bound to the top module; one clock domain. */
`timescale 1ns/1ps
module wake_checker (
   input wire logic ref_clk_i, // block clock
   input wire logic rstn_i, // standby reset, active low
   input wire logic reg_sel_i, // access targets the block
   input wire logic [7:0] reg_offset_i, // register offset
   input wire logic reg_wr_i, // write strobe
   input wire logic reg_rd_i, // read strobe
   input wire logic [wake_pkg::REG_W-1:0] reg_wdata_i, // write byte
   input wire logic [wake_pkg::REG_W-1:0] reg_rdata_o, // read byte
   input wire logic reg_rvalid_o, // read data valid
   input wire logic wake_request_n_o // wake request, active low
);
   import wake_pkg::*;
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (!rstn_i);
   // reads and master writes seen at this edge
   wire rd_hit = reg_sel_i && reg_rd_i;
   wire m_wr = reg_sel_i && reg_wr_i && (reg_offset_i == OFS_MASTER_STATUS
      || reg_offset_i == OFS_MASTER_ENABLE);
   wire rsv_hit = reg_offset_i == OFS_RESERVED_01
      || reg_offset_i == OFS_RESERVED_03 || reg_offset_i >= BLOCK_SPAN;
   sequence clr_s;
      m_wr && reg_offset_i == OFS_MASTER_STATUS && reg_wdata_i[MASTER_BIT];
   endsequence
   sequence off_s;
      m_wr && reg_offset_i == OFS_MASTER_ENABLE && !reg_wdata_i[MASTER_BIT];
   endsequence
   rvalid_follow_a: assert property (rd_hit |=> reg_rvalid_o)
      else $error("read not answered");
   read_idle_a: assert property (!rd_hit |=> !reg_rvalid_o
      && reg_rdata_o == 8'h00) else $error("read data without read");
   reserved_zero_a: assert property (rd_hit && rsv_hit
      |=> reg_rdata_o == 8'h00) else $error("reserved offset not zero");
   master_upper_a: assert property (rd_hit && !rsv_hit
      && reg_offset_i < OFS_SOURCE_STATUS_A |=> reg_rdata_o[7:1] == 7'h00)
      else $error("master reserved bits not zero");
   reset_quiet_a: assert property (disable iff (1'b0)
      !rstn_i |=> wake_request_n_o && !reg_rvalid_o)
      else $error("outputs active in reset");
   clear_drop_a: assert property (clr_s |-> ##[1:2] wake_request_n_o)
      else $error("request kept after master clear");
   disable_drop_a: assert property (off_s |-> ##[1:2] wake_request_n_o)
      else $error("request kept while disabled");
   request_hold_a: assert property (!wake_request_n_o && !m_wr
      && !$past(m_wr) |=> !wake_request_n_o)
      else $error("request dropped without cause");
endmodule : wake_checker

// *** bench/wake_event_status_control_tb.sv ***
/* testbench for the wake event block: register tasks and event pulses.
   assumes: package, design, checker and host model compiled first. */
`timescale 1ns/1ps
bind wake_event_status_control wake_checker chk_u (.ref_clk_i, .rstn_i,
   .reg_sel_i, .reg_offset_i, .reg_wr_i, .reg_rd_i, .reg_wdata_i,
   .reg_rdata_o, .reg_rvalid_o, .wake_request_n_o);
module wake_event_status_control_tb;
   import wake_pkg::*;
   logic ref_clk_i = 1'b0; // 250 MHz clock
   logic rstn_i = 1'b0; // standby reset
   logic sel = 1'b0, wr = 1'b0, rd = 1'b0; // register strobes
   logic [7:0] off = 8'h00, wdata = 8'h00, rdata; // register bytes
   logic rvalid, req_n, seen; // design and host outputs
   logic [SRC_W-1:0] ev = '0, en = '0; // event lines, source enables
   logic [7:0] rsv [3] = '{8'h01, 8'h03, 8'h07}; // refused offsets
   int num_errors = 0, comparisons = 0;
   initial forever #2 ref_clk_i = ~ref_clk_i;
   wake_event_status_control dut_u (.ref_clk_i, .rstn_i, .reg_sel_i(sel),
      .reg_offset_i(off), .reg_wr_i(wr), .reg_rd_i(rd), .reg_wdata_i(wdata),
      .reg_rdata_o(rdata), .reg_rvalid_o(rvalid),
      .consumer_infrared_wake_i(ev[0]), .ring_indicator_two_i(ev[1]),
      .ring_indicator_one_i(ev[2]), .keyboard_wake_i(ev[3]),
      .mouse_wake_i(ev[4]), .specific_key_wake_i(ev[5]),
      .fan_speed_sense_one_i(ev[6]), .fan_speed_sense_two_i(ev[7]),
      .general_pin_10_17_i(ev[15:8]), .general_pin_20_22_i(ev[18:16]),
      .grouped_device_interrupt_status_i(ev[19]),
      .general_pin_24_27_i(ev[23:20]), .wake_assert_enable_i(en),
      .wake_request_n_o(req_n));
   host_wake_monitor host_u (.ref_clk_i, .rstn_i,
      .wake_request_n_i(req_n), .wake_seen_o(seen));
   // compare one byte and count it
   task automatic chk(input string what, input logic [7:0] exp, got);
      comparisons++;
      if (got !== exp) begin
         num_errors++;
         $display("wrong value %s: expected %h, seen %h", what, exp, got);
      end
   endtask : chk
   // one write strobe, taken at the next edge
   task automatic wr_reg(input logic [7:0] o, d);
      @(posedge ref_clk_i);
      sel <= 1'b1;
      wr <= 1'b1;
      off <= o;
      wdata <= d;
      @(posedge ref_clk_i);
      sel <= 1'b0;
      wr <= 1'b0;
   endtask : wr_reg
   // one read strobe; data stands the cycle after it is taken
   task automatic rd_reg(input logic [7:0] o, exp, input string what);
      @(posedge ref_clk_i);
      sel <= 1'b1;
      rd <= 1'b1;
      off <= o;
      @(posedge ref_clk_i);
      sel <= 1'b0;
      rd <= 1'b0;
      #1;
      chk(what, exp, rdata);
   endtask : rd_reg
   // rising edge on one event line, held long enough to pass the filter
   task automatic fire(input int b);
      @(posedge ref_clk_i);
      ev[b] <= 1'b1;
      repeat (5) @(posedge ref_clk_i);
      ev[b] <= 1'b0;
      repeat (4) @(posedge ref_clk_i);
   endtask : fire
   task automatic close_out();
      $display("comparisons %0d, mismatches %0d", comparisons, num_errors);
      if (num_errors == 0 && comparisons > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : close_out
   // main sequence
   initial begin
      logic [7:0] o, x;
      repeat (16) @(posedge ref_clk_i);
      rstn_i <= 1'b1;
      for (int i = 0; i < 7; i++) rd_reg(8'(i), 8'h00, "reset");
      chk("request idle", 8'h01, {7'h00, req_n});
      foreach (rsv[i]) begin
         wr_reg(rsv[i], 8'hff);
         rd_reg(rsv[i], 8'h00, "reserved");
      end
      wr_reg(OFS_MASTER_ENABLE, 8'hff);
      rd_reg(OFS_MASTER_ENABLE, 8'h01, "enable");
      wr_reg(OFS_MASTER_ENABLE, 8'h00);
      $display("test done: reset and reserved");
      for (int b = 0; b < SRC_W; b++) begin
         fire(b);
         o = OFS_SOURCE_STATUS_A + 8'(b / 8);
         x = 8'h01 << (b % 8);
         rd_reg(o, x, "source bit");
         wr_reg(o, ~x);
         rd_reg(o, x, "zero write");
         wr_reg(o, x);
         rd_reg(o, 8'h00, "cleared");
         rd_reg(OFS_MASTER_STATUS, 8'h00, "master quiet");
      end
      $display("test done: source map");
      @(posedge ref_clk_i);
      en[BIT_KEYBOARD] <= 1'b1;
      fire(BIT_KEYBOARD);
      rd_reg(OFS_MASTER_STATUS, 8'h01, "master set");
      chk("request gated", 8'h01, {7'h00, req_n});
      wr_reg(OFS_MASTER_ENABLE, 8'h01);
      repeat (3) @(posedge ref_clk_i);
      #1 chk("request", 8'h00, {7'h00, req_n});
      chk("host saw", 8'h01, {7'h00, seen});
      wr_reg(OFS_MASTER_STATUS, 8'h01);
      rd_reg(OFS_MASTER_STATUS, 8'h01, "master reset by source");
      wr_reg(OFS_SOURCE_STATUS_A, 8'h08);
      wr_reg(OFS_MASTER_STATUS, 8'h01);
      repeat (3) @(posedge ref_clk_i);
      #1 chk("request off", 8'h01, {7'h00, req_n});
      $display("test done: wake path");
      fire(8);
      @(posedge ref_clk_i);
      rstn_i <= 1'b0;
      repeat (4) @(posedge ref_clk_i);
      rstn_i <= 1'b1;
      rd_reg(OFS_SOURCE_STATUS_B, 8'h00, "standby reset");
      rd_reg(OFS_MASTER_ENABLE, 8'h00, "standby reset");
      $display("test done: second reset");
      close_out();
   end
   // watchdog against a hang
   initial begin
      repeat (20000) @(posedge ref_clk_i);
      num_errors++;
      close_out();
   end
endmodule : wake_event_status_control_tb

// *** src/wake_bit.sv ***
/*
 * wake_bit: one sticky write-one-to-clear status bit; a new event in the
 * same cycle as a clear keeps the bit set.
 * assumes: ref_clk_i domain, reset is the standby-supply reset only.
 */
`timescale 1ns/1ps
module wake_bit (
   input wire logic ref_clk_i, // block clock
   input wire logic rstn_i, // standby reset, active low
   input wire logic set_i, // event pulse
   input wire logic clear_i, // host wrote one to this bit
   output logic state_o // sticky status
);
   import wake_pkg::*;

   logic state_d;

   // set beats clear in the same cycle
   assign state_d = set_i | (state_o & ~clear_i);

   // sticky flop, cleared by clear_i or by standby reset
   always_ff @(posedge ref_clk_i) begin
      if (!rstn_i) begin
         state_o <= MASTER_RESET;
      end else begin
         state_o <= state_d;
      end
   end
endmodule : wake_bit

// *** src/wake_event_status_control.sv ***
/*
 * wake_event_status_control: latches wake events into sticky status
 * registers, keeps the master status and enable bits, and drives the
 * active-low wake request toward the host chipset.
 * assumes: rstn_i is the standby-supply power-on reset only; main-supply,
 * hard and soft resets are not wired here. register port is a plain byte
 * port with one-cycle read and write strobes and an offset already
 * relative to the programmed block base. event lines are asynchronous.
 */
`timescale 1ns/1ps
module wake_event_status_control (
   input wire logic ref_clk_i, // 250 MHz block clock
   input wire logic rstn_i, // standby-supply reset, active low
   input wire logic reg_sel_i, // offset lies inside the block window
   input wire logic [7:0] reg_offset_i, // offset from programmed base
   input wire logic reg_wr_i, // one-cycle write strobe
   input wire logic reg_rd_i, // one-cycle read strobe
   input wire logic [wake_pkg::REG_W-1:0] reg_wdata_i, // write byte
   output logic [wake_pkg::REG_W-1:0] reg_rdata_o, // read byte
   output logic reg_rvalid_o, // read data valid, one cycle
   input wire logic consumer_infrared_wake_i, // infrared wake event
   input wire logic ring_indicator_two_i, // second ring indicator
   input wire logic ring_indicator_one_i, // first ring indicator
   input wire logic keyboard_wake_i, // keyboard wake event
   input wire logic mouse_wake_i, // mouse wake event
   input wire logic specific_key_wake_i, // specific key wake event
   input wire logic fan_speed_sense_one_i, // fan tachometer one event
   input wire logic fan_speed_sense_two_i, // fan tachometer two event
   input wire logic [7:0] general_pin_10_17_i, // pins 10..17 events
   input wire logic [2:0] general_pin_20_22_i, // pins 20..22 events
   input wire logic grouped_device_interrupt_status_i, // group interrupt
   input wire logic [3:0] general_pin_24_27_i, // pins 24..27 events
   input wire logic [wake_pkg::SRC_W-1:0] wake_assert_enable_i, // per-source
   output logic wake_request_n_o // wake request, active low
);
   import wake_pkg::*;

   // raw event vector in register order: bank a, bank b, bank c
   logic [SRC_W-1:0] event_raw;
   logic [SRC_W-1:0] event_rise; // synchronised rising edges
   logic [SRC_W-1:0] source_q; // sticky per-source status
   logic [SRC_W-1:0] source_clear; // write-one-to-clear strobes
   logic master_status; // master status flop output
   logic master_enable_q; // master enable
   logic master_enable_d;
   logic master_clear; // write one to master status
   logic master_set; // some enabled source is pending
   logic request_d; // next wake request, active high
   logic in_block; // offset inside decoded span
   logic hit_mstat; // decoded master status
   logic hit_men; // decoded master enable
   logic hit_a; // decoded bank a
   logic hit_b; // decoded bank b
   logic hit_c; // decoded bank c
   logic wr_mstat;
   logic wr_men;
   logic wr_a;
   logic wr_b;
   logic wr_c;
   logic [REG_W-1:0] rdata_d; // read mux output

   // bank a layout: sources placed at their documented bit positions
   assign event_raw[BIT_INFRARED] = consumer_infrared_wake_i;
   assign event_raw[BIT_RING_TWO] = ring_indicator_two_i;
   assign event_raw[BIT_RING_ONE] = ring_indicator_one_i;
   assign event_raw[BIT_KEYBOARD] = keyboard_wake_i;
   assign event_raw[BIT_MOUSE] = mouse_wake_i;
   assign event_raw[BIT_SPECIFIC_KEY] = specific_key_wake_i;
   assign event_raw[BIT_FAN_ONE] = fan_speed_sense_one_i;
   assign event_raw[BIT_FAN_TWO] = fan_speed_sense_two_i;
   // bank b: pins 10..17 in order
   assign event_raw[2*REG_W-1:REG_W] = general_pin_10_17_i;
   // bank c: pins 20..22, grouped interrupt, pins 24..27
   assign event_raw[2*REG_W+2:2*REG_W] = general_pin_20_22_i;
   assign event_raw[2*REG_W+BIT_GROUPED_INT] =
      grouped_device_interrupt_status_i;
   assign event_raw[3*REG_W-1:2*REG_W+4] = general_pin_24_27_i;
   // pins 32, 33 and 53 live in banks d and e, which this block omits, so
   // their false setting at main-supply power-up cannot raise a wake

   // address decode relative to the programmed base
   assign in_block = reg_sel_i & (reg_offset_i < BLOCK_SPAN);
   assign hit_mstat = in_block & (reg_offset_i == OFS_MASTER_STATUS);
   assign hit_men = in_block & (reg_offset_i == OFS_MASTER_ENABLE);
   assign hit_a = in_block & (reg_offset_i == OFS_SOURCE_STATUS_A);
   assign hit_b = in_block & (reg_offset_i == OFS_SOURCE_STATUS_B);
   assign hit_c = in_block & (reg_offset_i == OFS_SOURCE_STATUS_C);
   assign wr_mstat = hit_mstat & reg_wr_i;
   assign wr_men = hit_men & reg_wr_i;
   assign wr_a = hit_a & reg_wr_i;
   assign wr_b = hit_b & reg_wr_i;
   assign wr_c = hit_c & reg_wr_i;

   // write-one-to-clear strobes, zero bits ignored
   assign source_clear = {reg_wdata_i & {REG_W{wr_c}},
                          reg_wdata_i & {REG_W{wr_b}},
                          reg_wdata_i & {REG_W{wr_a}}};

   // master status clear on a written one in bit 0
   assign master_clear = wr_mstat & reg_wdata_i[MASTER_BIT];

   // enable is plain read-write on bit 0; upper bits reserved
   assign master_enable_d = wr_men ? reg_wdata_i[MASTER_BIT]
                                   : master_enable_q;

   // a source would request when set and individually enabled
   assign master_set = |(source_q & wake_assert_enable_i);

   // request: pending master status gated by master enable
   // the master bit itself already reflects source and enable
   assign request_d = master_status & master_enable_q & ~master_clear;

   // read mux; reserved offsets and bits return zero
   assign rdata_d =
      hit_mstat ? {{(REG_W-1){1'b0}}, master_status} :
      hit_men ? {{(REG_W-1){1'b0}}, master_enable_q} :
      hit_a ? source_q[REG_W-1:0] :
      hit_b ? source_q[2*REG_W-1:REG_W] :
      hit_c ? source_q[3*REG_W-1:2*REG_W] :
      RESET_VALUE;

   // one synchroniser and one sticky bit per wake source
   genvar g;
   generate
      for (g = 0; g < SRC_W; g++) begin : g_src
         // pin lines are asynchronous: three-flop filter
         wake_sync u_sync (
            .ref_clk_i(ref_clk_i),
            .rstn_i(rstn_i),
            .async_i(event_raw[g]),
            .rise_o(event_rise[g])
         );
         // sets on any event whatever the enables
         // a written one or the standby reset clears it
         wake_bit u_bit (
            .ref_clk_i(ref_clk_i),
            .rstn_i(rstn_i),
            .set_i(event_rise[g]),
            .clear_i(source_clear[g]),
            .state_o(source_q[g])
         );
      end
   endgenerate

   // master status: sets whenever a request would be made, regardless of
   // the master enable; set beats a simultaneous clear
   wake_bit u_master (
      .ref_clk_i(ref_clk_i),
      .rstn_i(rstn_i),
      .set_i(master_set),
      .clear_i(master_clear),
      .state_o(master_status)
   );

   // master enable, a written zero or the standby reset clears it
   always_ff @(posedge ref_clk_i) begin
      if (!rstn_i) begin
         master_enable_q <= MASTER_RESET;
      end else begin
         master_enable_q <= master_enable_d;
      end
   end

   // registered wake request, high when idle
   always_ff @(posedge ref_clk_i) begin
      if (!rstn_i) begin
         wake_request_n_o <= 1'b1;
      end else begin
         wake_request_n_o <= ~request_d;
      end
   end

   // registered read data with valid
   always_ff @(posedge ref_clk_i) begin
      if (!rstn_i) begin
         reg_rdata_o <= RESET_VALUE;
         reg_rvalid_o <= 1'b0;
      end else begin
         reg_rdata_o <= reg_rd_i ? rdata_d : RESET_VALUE;
         reg_rvalid_o <= reg_rd_i & reg_sel_i;
      end
   end
endmodule : wake_event_status_control

// *** src/wake_pkg.sv ***
/*
 * wake_pkg: offsets, bit positions, reset values and widths shared by the
 * wake event status and control block.
 * assumes: byte-wide register port, offsets relative to the programmed
 * base of the power management register block.
 */
package wake_pkg;
   // register offsets within the wake block
   localparam logic [7:0] OFS_MASTER_STATUS = 8'h00;
   localparam logic [7:0] OFS_RESERVED_01 = 8'h01;
   localparam logic [7:0] OFS_MASTER_ENABLE = 8'h02;
   localparam logic [7:0] OFS_RESERVED_03 = 8'h03;
   localparam logic [7:0] OFS_SOURCE_STATUS_A = 8'h04;
   localparam logic [7:0] OFS_SOURCE_STATUS_B = 8'h05;
   localparam logic [7:0] OFS_SOURCE_STATUS_C = 8'h06;
   // span of the decoded block (offsets 00..06)
   localparam logic [7:0] BLOCK_SPAN = 8'h07;
   // master bit position
   localparam int MASTER_BIT = 0;
   // standby reset values
   localparam logic [7:0] RESET_VALUE = 8'h00;
   localparam logic MASTER_RESET = 1'b0;
   // register bank A bit positions
   localparam int BIT_INFRARED = 0;
   localparam int BIT_RING_TWO = 1;
   localparam int BIT_RING_ONE = 2;
   localparam int BIT_KEYBOARD = 3;
   localparam int BIT_MOUSE = 4;
   localparam int BIT_SPECIFIC_KEY = 5;
   localparam int BIT_FAN_ONE = 6;
   localparam int BIT_FAN_TWO = 7;
   // register bank C: grouped interrupt position
   localparam int BIT_GROUPED_INT = 3;
   // widths
   localparam int REG_W = 8;
   localparam int SRC_W = 24;
   // synchroniser depth for pin inputs
   localparam int SYNC_DEPTH = 3;
endpackage : wake_pkg

// *** src/wake_sync.sv ***
/*
 * wake_sync: three-flop synchroniser with agreement filter for one
 * asynchronous wake event line; emits a one-cycle pulse on a rising edge.
 * assumes: ref_clk_i domain, synchronous active-low reset.
 */
`timescale 1ns/1ps
module wake_sync (
   input wire logic ref_clk_i, // block clock
   input wire logic rstn_i, // synchronous reset, active low
   input wire logic async_i, // raw event line from a pin
   output logic rise_o // one-cycle pulse when the line goes high
);
   import wake_pkg::*;

   logic [SYNC_DEPTH-1:0] chain_q; // stage 0 is read only by stage 1
   logic level_q; // filtered level
   logic agree; // second and third stages match
   logic level_d;

   assign agree = (chain_q[1] == chain_q[2]);
   assign level_d = agree ? chain_q[2] : level_q;

   // shift chain and filtered level
   always_ff @(posedge ref_clk_i) begin
      if (!rstn_i) begin
         chain_q <= '0;
         level_q <= 1'b0;
         rise_o <= 1'b0;
      end else begin
         chain_q <= {chain_q[SYNC_DEPTH-2:0], async_i};
         level_q <= level_d;
         rise_o <= level_d & ~level_q;
      end
   end
endmodule : wake_sync
